/* File: rtl/nsr_pkg.sv */
// Constants for the network status and event reporter.
// Assumes a 32-bit register port addressed in bytes on the host clock.
package nsr_pkg;

  // Byte offset of the status report word in the register space.
  localparam logic [7:0] NSR_REPORT_OFFSET = 8'h28;

  // Reset value: bits 31:26 read as ones, everything else clear.
  localparam logic [31:0] NSR_RESET_VALUE = 32'hfc000000;
  localparam logic [31:0] NSR_FIXED_ONES = 32'hfc000000;

  // Field positions of the status report word.
  localparam int NSR_BERR_TYPE_LSB = 23;
  localparam int NSR_TX_STATE_LSB = 20;
  localparam int NSR_RX_STATE_LSB = 17;
  localparam int NSR_NORMAL_SUM_BIT = 16;
  localparam int NSR_ABNORMAL_SUM_BIT = 15;
  localparam int NSR_BERR_BIT = 13;
  localparam int NSR_TIMER_BIT = 11;
  localparam int NSR_TX_EARLY_BIT = 10;
  localparam int NSR_RX_WDOG_BIT = 9;
  localparam int NSR_RX_STOP_BIT = 8;
  localparam int NSR_RX_BUF_BIT = 7;
  localparam int NSR_RX_DONE_BIT = 6;
  localparam int NSR_TX_UNDER_BIT = 5;
  localparam int NSR_TX_JABBER_BIT = 3;
  localparam int NSR_TX_BUF_BIT = 2;
  localparam int NSR_TX_STOP_BIT = 1;
  localparam int NSR_TX_DONE_BIT = 0;

  // Width of the flag bank, bits 16 down to 0.
  localparam int NSR_FLAG_W = 17;

  // Flags that exist; bits 4, 12 and 14 are reserved and read as zero.
  localparam logic [16:0] NSR_FLAG_EXIST = 17'h1afef;
  // Flags cleared by writing a one (bits 16 down to 1).
  localparam logic [16:0] NSR_FLAG_W1C = 17'h1fffe;
  // Members of the normal summary: bits 0, 2 and 6.
  localparam logic [16:0] NSR_NORMAL_SET = 17'h00045;
  // Members of the abnormal summary: bits 1,3,5,7,8,9,10,11,13.
  localparam logic [16:0] NSR_ABNORMAL_SET = 17'h02faa;

  // Bus error categories.
  typedef enum logic [2:0]
  {
    NSR_BERR_PARITY = 3'h0,
    NSR_BERR_MASTER = 3'h1,
    NSR_BERR_SLAVE = 3'h2
  } nsr_berr_type;

  // Transmit engine state codes.
  localparam logic [2:0] NSR_TX_STOPPED = 3'h0;
  localparam logic [2:0] NSR_TX_SUSPENDED = 3'h7;
  // Receive engine state codes.
  localparam logic [2:0] NSR_RX_STOPPED = 3'h0;
  localparam logic [2:0] NSR_RX_SUSPENDED = 3'h6;

endpackage

/* File: rtl/nsr_flag_if.sv */
// Carrier between the reporter top and its sticky flag bank.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface nsr_flag_if #(parameter int W = 17);
  logic [W-1:0] set_vec;
  logic [W-1:0] clr_vec;
  logic [W-1:0] flags;
  // The top drives set and clear requests and reads the flags back.
  modport ctrl (output set_vec, output clr_vec, input flags);
  // The bank holds the flags.
  modport bank (input set_vec, input clr_vec, output flags);
endinterface

/* File: rtl/nsr_flag_bank.sv */
// Sticky flag bank: hardware sets, software clears, set wins.
// Assumes clear requests are already masked to clearable bits.
`timescale 1ns/1ps
module nsr_flag_bank #(
  parameter int W = 17,
  parameter logic [W-1:0] EXIST = '1
)(
  input wire logic clock,
  input wire logic rstn,
  input wire logic soft_rst,
  nsr_flag_if.bank fl
);

  logic [W-1:0] flag_reg;
  logic [W-1:0] flag_next;

  // A set in the same cycle as a clear keeps the flag.
  assign flag_next = ((flag_reg & ~fl.clr_vec) | fl.set_vec) & EXIST;
  assign fl.flags = flag_reg;

  // Software reset clears the bank like the hardware reset.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      flag_reg <= '0;
    else if (soft_rst)
      flag_reg <= '0;
    else
      flag_reg <= flag_next;
  end

endmodule

/* File: rtl/nsr_reporter.sv */
// Network status report register with its event flags and summaries.
// Assumes event inputs are one-cycle pulses synchronous to clock, and
// the engine state codes and mask enables are driven by other blocks.
`timescale 1ns/1ps
module nsr_reporter #(
  parameter int ADDR_W = 8
)(
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              soft_rst,
  input  wire logic [ADDR_W-1:0] csr_addr,
  input  wire logic              csr_wr,
  input  wire logic              csr_rd,
  input  wire logic [31:0]       csr_wdata,
  output logic      [31:0]       csr_rdata,
  output logic                   csr_rvalid,
  input  wire logic [2:0]        tx_engine_state,
  input  wire logic [2:0]        rx_engine_state,
  input  wire logic              tx_complete_evt,
  input  wire logic              tx_early_evt,
  input  wire logic              tx_underrun_evt,
  input  wire logic              tx_jabber_evt,
  input  wire logic              tx_buf_unavail_evt,
  input  wire logic              tx_poll_demand,
  input  wire logic              tx_autopoll_timeout,
  input  wire logic              rx_complete_evt,
  input  wire logic              rx_buf_unavail_evt,
  input  wire logic              rx_watchdog_evt,
  input  wire logic              rx_frame_arrived,
  input  wire logic              rx_poll_demand,
  input  wire logic              timer_expired_evt,
  input  wire logic              bus_error_evt,
  input  wire logic [2:0]        bus_error_code,
  input  wire logic              normal_summary_enable,
  input  wire logic              abnormal_summary_enable,
  input  wire logic              bus_error_enable,
  output logic                   irq,
  output logic                   tx_suspend_hold,
  output logic                   rx_suspend_hold,
  output logic                   tx_abort,
  output logic                   tx_force_stop,
  output logic                   desc_underrun_mark,
  output logic                   desc_jabber_mark,
  output logic                   tx_fetch_next,
  output logic                   rx_fetch_next
);

  // The report offset must fit in the address port.
  if (ADDR_W < 7)
  begin : g_addr_w_check
    $error("nsr_reporter: ADDR_W too narrow for the report offset");
  end

  localparam int FW = nsr_pkg::NSR_FLAG_W;

  // Returns a one-hot flag vector with bit pos set when cond is true.
  function automatic logic [FW-1:0] flag_bit(input logic cond,
                                             input int pos);
    logic [FW-1:0] v;
    v = '0;
    v[pos] = cond;
    return v;
  endfunction

  // Engine state mirrors and the recorded bus error type.
  logic [2:0]  tx_state_reg;
  logic [2:0]  rx_state_reg;
  logic [2:0]  berr_type_reg;
  logic [2:0]  berr_type_next;

  // Register port outputs.
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rvalid_reg;

  // Control outputs towards the descriptor engines.
  logic        irq_reg;
  logic        irq_next;
  logic        tx_hold_reg;
  logic        tx_hold_next;
  logic        rx_hold_reg;
  logic        rx_hold_next;
  logic        tx_abort_reg;
  logic        tx_stop_reg;
  logic        under_mark_reg;
  logic        jabber_mark_reg;
  logic        tx_fetch_reg;
  logic        rx_fetch_reg;

  nsr_flag_if #(.W(FW)) fl ();

  // Address decode of the single report word.
  logic        hit;
  logic        wr_hit;
  logic        rd_hit;
  assign hit = (csr_addr == ADDR_W'(nsr_pkg::NSR_REPORT_OFFSET));
  assign wr_hit = csr_wr & hit;
  assign rd_hit = csr_rd & hit;

  // Stopped-state entry is a change of the mirrored code into stopped.
  logic        tx_enter_stop;
  logic        rx_enter_stop;
  assign tx_enter_stop = (tx_engine_state == nsr_pkg::NSR_TX_STOPPED) &&
                         (tx_state_reg != nsr_pkg::NSR_TX_STOPPED);
  assign rx_enter_stop = (rx_engine_state == nsr_pkg::NSR_RX_STOPPED) &&
                         (rx_state_reg != nsr_pkg::NSR_RX_STOPPED);

  // The early flag is only set when transmit done does not arrive in
  // the same cycle; otherwise the automatic clear would be undone.
  logic        tx_early_set;
  assign tx_early_set = tx_early_evt & ~tx_complete_evt;

  // Event set vector; each event feeds exactly one flag.
  logic [FW-1:0] ev_set;
  assign ev_set =
    flag_bit(tx_complete_evt, nsr_pkg::NSR_TX_DONE_BIT) |
    flag_bit(tx_enter_stop, nsr_pkg::NSR_TX_STOP_BIT) |
    flag_bit(tx_buf_unavail_evt, nsr_pkg::NSR_TX_BUF_BIT) |
    flag_bit(tx_jabber_evt, nsr_pkg::NSR_TX_JABBER_BIT) |
    flag_bit(tx_underrun_evt, nsr_pkg::NSR_TX_UNDER_BIT) |
    flag_bit(rx_complete_evt, nsr_pkg::NSR_RX_DONE_BIT) |
    flag_bit(rx_buf_unavail_evt, nsr_pkg::NSR_RX_BUF_BIT) |
    flag_bit(rx_enter_stop, nsr_pkg::NSR_RX_STOP_BIT) |
    flag_bit(rx_watchdog_evt, nsr_pkg::NSR_RX_WDOG_BIT) |
    flag_bit(tx_early_set, nsr_pkg::NSR_TX_EARLY_BIT) |
    flag_bit(timer_expired_evt, nsr_pkg::NSR_TIMER_BIT) |
    flag_bit(bus_error_evt, nsr_pkg::NSR_BERR_BIT);

  // Summaries are set from their member flags after this cycle's clears and
  // events, so a summary never outlives members cleared with it.
  logic [FW-1:0] member_now;
  logic          normal_any;
  logic          abnormal_any;
  assign member_now = (fl.flags & ~fl.clr_vec) | ev_set;
  assign normal_any = |(member_now & nsr_pkg::NSR_NORMAL_SET);
  assign abnormal_any = |(member_now & nsr_pkg::NSR_ABNORMAL_SET);

  logic [FW-1:0] sum_set;
  assign sum_set =
    flag_bit(normal_any, nsr_pkg::NSR_NORMAL_SUM_BIT) |
    flag_bit(abnormal_any, nsr_pkg::NSR_ABNORMAL_SUM_BIT);

  // Software clears only the write-one-clear bits it writes ones to;
  // zeros and the read-only fields above bit 16 are ignored.
  logic [FW-1:0] sw_clr;
  assign sw_clr = wr_hit ? (csr_wdata[FW-1:0] & nsr_pkg::NSR_FLAG_W1C)
                         : '0;

  // Hardware clear of the early flag by the transmit done event.
  logic [FW-1:0] hw_clr;
  assign hw_clr = flag_bit(tx_complete_evt, nsr_pkg::NSR_TX_EARLY_BIT);

  assign fl.set_vec = ev_set | sum_set;
  assign fl.clr_vec = sw_clr | hw_clr;

  nsr_flag_bank #(
    .W     (FW),
    .EXIST (nsr_pkg::NSR_FLAG_EXIST)
  ) u_bank (
    .clock    (clock),
    .rstn     (rstn),
    .soft_rst (soft_rst),
    .fl       (fl)
  );

  // The type field is refreshed on every bus error so that it always
  // describes the latest one; it is only meaningful while the flag is.
  assign berr_type_next = bus_error_evt ? bus_error_code
                                        : berr_type_reg;

  // Read image of the report word; reserved bits read as zero.
  logic [31:0] image;
  assign image = nsr_pkg::NSR_FIXED_ONES |
    (32'(berr_type_reg) << nsr_pkg::NSR_BERR_TYPE_LSB) |
    (32'(tx_state_reg) << nsr_pkg::NSR_TX_STATE_LSB) |
    (32'(rx_state_reg) << nsr_pkg::NSR_RX_STATE_LSB) |
    32'(fl.flags);
  assign rdata_next = rd_hit ? image : 32'h00000000;

  // Interrupt: normal path gated by its enable, abnormal path by its
  // enable, with the bus error also needing its own enable.
  logic        irq_normal;
  logic        irq_berr;
  logic        irq_abn_other;
  logic [FW-1:0] abn_other_set;
  assign irq_normal = fl.flags[nsr_pkg::NSR_NORMAL_SUM_BIT] &
                      normal_summary_enable;
  assign irq_berr = fl.flags[nsr_pkg::NSR_BERR_BIT] &
                    bus_error_enable & abnormal_summary_enable;
  assign abn_other_set = nsr_pkg::NSR_ABNORMAL_SET &
                         ~flag_bit(1'b1, nsr_pkg::NSR_BERR_BIT);
  assign irq_abn_other = |(fl.flags & abn_other_set) &
                         fl.flags[nsr_pkg::NSR_ABNORMAL_SUM_BIT] &
                         abnormal_summary_enable;
  assign irq_next = irq_normal | irq_berr | irq_abn_other;

  // Transmit suspend hold: set by a host-owned descriptor or underrun,
  // released by a poll demand, the automatic polling timeout or a jabber
  // event. A new cause in the release cycle keeps the hold.
  assign tx_hold_next = tx_buf_unavail_evt | tx_underrun_evt |
                        (tx_hold_reg & ~tx_poll_demand &
                         ~tx_autopoll_timeout & ~tx_jabber_evt);

  // Receive suspend hold: released by a new frame or a poll demand.
  assign rx_hold_next = rx_buf_unavail_evt |
                        (rx_hold_reg & ~rx_frame_arrived &
                         ~rx_poll_demand);

  // Register port and state mirrors.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_reg <= 32'h00000000;
      rvalid_reg <= 1'b0;
      tx_state_reg <= nsr_pkg::NSR_TX_STOPPED;
      rx_state_reg <= nsr_pkg::NSR_RX_STOPPED;
      berr_type_reg <= 3'h0;
    end
    else if (soft_rst)
    begin
      rdata_reg <= 32'h00000000;
      rvalid_reg <= 1'b0;
      tx_state_reg <= nsr_pkg::NSR_TX_STOPPED;
      rx_state_reg <= nsr_pkg::NSR_RX_STOPPED;
      berr_type_reg <= 3'h0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      rvalid_reg <= csr_rd;
      tx_state_reg <= tx_engine_state;
      rx_state_reg <= rx_engine_state;
      berr_type_reg <= berr_type_next;
    end
  end

  // Interrupt and suspend holds.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_reg <= 1'b0;
      tx_hold_reg <= 1'b0;
      rx_hold_reg <= 1'b0;
    end
    else if (soft_rst)
    begin
      irq_reg <= 1'b0;
      tx_hold_reg <= 1'b0;
      rx_hold_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= irq_next;
      tx_hold_reg <= tx_hold_next;
      rx_hold_reg <= rx_hold_next;
    end
  end

  // One-cycle commands to the descriptor engines, one cycle after the
  // event; they carry no state so a repeat event simply repeats them.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_abort_reg <= 1'b0;
      tx_stop_reg <= 1'b0;
      under_mark_reg <= 1'b0;
      jabber_mark_reg <= 1'b0;
      tx_fetch_reg <= 1'b0;
      rx_fetch_reg <= 1'b0;
    end
    else if (soft_rst)
    begin
      tx_abort_reg <= 1'b0;
      tx_stop_reg <= 1'b0;
      under_mark_reg <= 1'b0;
      jabber_mark_reg <= 1'b0;
      tx_fetch_reg <= 1'b0;
      rx_fetch_reg <= 1'b0;
    end
    else
    begin
      tx_abort_reg <= tx_jabber_evt;
      tx_stop_reg <= tx_jabber_evt;
      jabber_mark_reg <= tx_jabber_evt;
      under_mark_reg <= tx_underrun_evt;
      tx_fetch_reg <= tx_complete_evt;
      rx_fetch_reg <= rx_complete_evt;
    end
  end

  // Every output comes straight from a flip-flop.
  assign csr_rdata = rdata_reg;
  assign csr_rvalid = rvalid_reg;
  assign irq = irq_reg;
  assign tx_suspend_hold = tx_hold_reg;
  assign rx_suspend_hold = rx_hold_reg;
  assign tx_abort = tx_abort_reg;
  assign tx_force_stop = tx_stop_reg;
  assign desc_underrun_mark = under_mark_reg;
  assign desc_jabber_mark = jabber_mark_reg;
  assign tx_fetch_next = tx_fetch_reg;
  assign rx_fetch_next = rx_fetch_reg;

endmodule

/* File: tb/nsr_reporter_properties.sv */
// Port-level assertions for the network status reporter.
// Assumes one clock; rstn and soft_rst both return the block to reset.
`timescale 1ns/1ps
module nsr_reporter_properties #(
  parameter int ADDR_W = 8
)(
  input wire logic              clock,
  input wire logic              rstn,
  input wire logic              soft_rst,
  input wire logic [ADDR_W-1:0] csr_addr,
  input wire logic              csr_rd,
  input wire logic [31:0]       csr_rdata,
  input wire logic              csr_rvalid,
  input wire logic [2:0]        tx_engine_state,
  input wire logic [2:0]        rx_engine_state,
  input wire logic              tx_jabber_evt,
  input wire logic              tx_underrun_evt,
  input wire logic              tx_complete_evt,
  input wire logic              tx_buf_unavail_evt,
  input wire logic              rx_buf_unavail_evt,
  input wire logic              rx_frame_arrived,
  input wire logic              rx_poll_demand,
  input wire logic              bus_error_evt,
  input wire logic              normal_summary_enable,
  input wire logic              abnormal_summary_enable,
  input wire logic              bus_error_enable,
  input wire logic              irq,
  input wire logic              tx_abort,
  input wire logic              tx_force_stop,
  input wire logic              desc_jabber_mark,
  input wire logic              desc_underrun_mark,
  input wire logic              tx_fetch_next,
  input wire logic              tx_suspend_hold,
  input wire logic              rx_suspend_hold,
  input wire logic              rx_complete_evt,
  input wire logic              rx_fetch_next
);
  // A read of the report word; its image shows the state mirrors that
  // were sampled one cycle before the read edge.
  logic rd_report;
  assign rd_report = csr_rd &&
                     (csr_addr == ADDR_W'(nsr_pkg::NSR_REPORT_OFFSET));
  default clocking cb @(posedge clock);
  endclocking
  // A soft reset clears like rstn, so both silence the checks.
  default disable iff (!rstn || soft_rst);

  // A lone jabber event gives a one-cycle burst of the three side effects.
  sequence jab_s;
    tx_jabber_evt ##1 !tx_jabber_evt;
  endsequence
  sequence jab_resp_s;
    tx_abort && tx_force_stop && desc_jabber_mark;
  endsequence
  sequence berr_s;
    bus_error_evt ##1 (bus_error_enable && abnormal_summary_enable);
  endsequence

  AST_JABBER: assert property (jab_s |-> jab_resp_s ##1 !tx_abort)
    else $error("jabber side effects wrong");
  AST_UNDERRUN: assert property (tx_underrun_evt |=>
    desc_underrun_mark && tx_suspend_hold)
    else $error("underrun side effects wrong");
  AST_TX_FETCH: assert property (tx_complete_evt |=> tx_fetch_next)
    else $error("no fetch after transmit complete");
  AST_RX_FETCH: assert property (rx_complete_evt |=> rx_fetch_next)
    else $error("no fetch after receive complete");
  AST_TX_HOLD: assert property (tx_buf_unavail_evt |=> tx_suspend_hold)
    else $error("transmit hold not raised");
  AST_RX_HOLD: assert property (rx_buf_unavail_evt ##1
    !(rx_frame_arrived || rx_poll_demand) |-> rx_suspend_hold[*2])
    else $error("receive hold not kept");
  AST_BERR_IRQ: assert property (berr_s |=> irq)
    else $error("bus error interrupt missing");
  AST_NO_IRQ: assert property (!normal_summary_enable &&
    !abnormal_summary_enable |=> !irq)
    else $error("interrupt with all enables off");
  AST_TX_STATE: assert property (rd_report |=>
    csr_rvalid && csr_rdata[22:20] == $past(tx_engine_state, 2))
    else $error("transmit state field wrong");
  AST_RX_STATE: assert property (rd_report |=>
    csr_rdata[19:17] == $past(rx_engine_state, 2))
    else $error("receive state field wrong");
  AST_NORMAL_SUM: assert property (csr_rvalid &&
    (csr_rdata[16:0] & nsr_pkg::NSR_NORMAL_SET) != 17'h0 |-> csr_rdata[16])
    else $error("normal summary missing");
  AST_ABNORMAL_SUM: assert property (csr_rvalid &&
    (csr_rdata[16:0] & nsr_pkg::NSR_ABNORMAL_SET) != 17'h0 |-> csr_rdata[15])
    else $error("abnormal summary missing");
endmodule

bind nsr_reporter nsr_reporter_properties #(.ADDR_W(ADDR_W)) u_props (
  .clock(clock), .rstn(rstn), .soft_rst(soft_rst), .csr_addr(csr_addr),
  .csr_rd(csr_rd), .csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid),
  .tx_engine_state(tx_engine_state), .rx_engine_state(rx_engine_state),
  .tx_jabber_evt(tx_jabber_evt), .tx_underrun_evt(tx_underrun_evt),
  .tx_complete_evt(tx_complete_evt), .bus_error_evt(bus_error_evt),
  .tx_buf_unavail_evt(tx_buf_unavail_evt), .rx_poll_demand(rx_poll_demand),
  .rx_buf_unavail_evt(rx_buf_unavail_evt), .rx_frame_arrived(rx_frame_arrived),
  .normal_summary_enable(normal_summary_enable), .irq(irq),
  .abnormal_summary_enable(abnormal_summary_enable),
  .bus_error_enable(bus_error_enable), .tx_abort(tx_abort),
  .tx_force_stop(tx_force_stop), .desc_jabber_mark(desc_jabber_mark),
  .desc_underrun_mark(desc_underrun_mark), .tx_fetch_next(tx_fetch_next),
  .tx_suspend_hold(tx_suspend_hold), .rx_suspend_hold(rx_suspend_hold),
  .rx_complete_evt(rx_complete_evt), .rx_fetch_next(rx_fetch_next));

/* File: tb/nsr_reporter_test.sv */
// Self-checking bench for the network status reporter.
// Assumes the bench alone drives every port of the reporter.
`timescale 1ns/1ps
module nsr_reporter_test;
  logic        clock, rstn, soft_rst, csr_wr, csr_rd, csr_rvalid, irq;
  logic        tsh, rsh;
  logic [7:0]  csr_addr;
  logic [31:0] csr_wdata, csr_rdata;
  logic [2:0]  txs, rxs, berr, en;
  logic [9:0]  ev;
  logic [3:0]  rel;
  logic [16:0] fl;
  int          error_cnt, checks_done;
  int          cyc = 0;
  // Flag position of each event line, in the order of ev.
  localparam int POS[10] = '{0, 10, 5, 3, 2, 6, 7, 9, 11, 13};

  nsr_reporter dut (
    .clock(clock), .rstn(rstn), .soft_rst(soft_rst), .csr_addr(csr_addr),
    .csr_wr(csr_wr), .csr_rd(csr_rd), .csr_wdata(csr_wdata),
    .csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid),
    .tx_engine_state(txs), .rx_engine_state(rxs),
    .tx_complete_evt(ev[0]), .tx_early_evt(ev[1]), .tx_underrun_evt(ev[2]),
    .tx_jabber_evt(ev[3]), .tx_buf_unavail_evt(ev[4]),
    .rx_complete_evt(ev[5]), .rx_buf_unavail_evt(ev[6]),
    .rx_watchdog_evt(ev[7]), .timer_expired_evt(ev[8]),
    .bus_error_evt(ev[9]), .bus_error_code(berr),
    .tx_poll_demand(rel[0]), .tx_autopoll_timeout(rel[1]),
    .rx_frame_arrived(rel[2]), .rx_poll_demand(rel[3]),
    .normal_summary_enable(en[0]), .abnormal_summary_enable(en[1]),
    .bus_error_enable(en[2]), .irq(irq), .tx_suspend_hold(tsh),
    .rx_suspend_hold(rsh), .tx_abort(), .tx_force_stop(),
    .desc_underrun_mark(), .desc_jabber_mark(), .tx_fetch_next(),
    .rx_fetch_next());

  // Free-running 40 MHz clock.
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Expected word: fixed ones, fields, flags, and summaries from members.
  function automatic logic [31:0] img();
    logic [16:0] f;
    f = fl;
    f[16] = |(fl & nsr_pkg::NSR_NORMAL_SET);
    f[15] = |(fl & nsr_pkg::NSR_ABNORMAL_SET);
    return nsr_pkg::NSR_FIXED_ONES | {6'h0, berr, txs, rxs, f};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One read; unmapped addresses must answer zero.
  task automatic rd_chk(input logic [7:0] a);
    @(posedge clock);
    csr_rd <= 1'b1;
    csr_addr <= a;
    @(posedge clock);
    csr_rd <= 1'b0;
    #1 check(csr_rdata, (a == 8'h28) ? img() : 32'h0);
  endtask

  // One write, plus an idle edge so the summaries settle.
  task automatic wr(input logic [31:0] d);
    @(posedge clock);
    csr_wr <= 1'b1;
    csr_wdata <= d;
    csr_addr <= 8'h28;
    @(posedge clock);
    csr_wr <= 1'b0;
    @(posedge clock);
  endtask

  // One-cycle event pulse; transmit complete also drops the early flag.
  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev[i] <= 1'b0;
    fl[POS[i]] = 1'b1;
    if (i == 0)
      fl[10] = 1'b0;
  endtask

  task automatic stop_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // A hung sequence is cut short and counted as a mismatch.
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  initial
  begin
    {rstn, soft_rst, csr_wr, csr_rd} = 4'h0;
    {csr_addr, csr_wdata, txs, rxs, berr, en, ev, rel, fl} = '0;
    error_cnt = 0;
    checks_done = 0;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    rd_chk(8'h28);
    rd_chk(8'h30);
    // Every state code in both fields; rx falls 1 to 0 at the last step.
    for (int s = 0; s < 8; s++)
    begin
      @(posedge clock);
      txs <= s[2:0];
      rxs <= 3'(7 - s);
      if (s == 7)
        fl[8] = 1'b1;
      rd_chk(8'h28);
    end
    @(posedge clock);
    txs <= 3'h0;
    fl[1] = 1'b1;
    rd_chk(8'h28);
    repeat (2) @(posedge clock);
    #1 check({31'h0, irq}, 32'h0);
    @(posedge clock);
    en <= 3'b010;
    repeat (3) @(posedge clock);
    #1 check({31'h0, irq}, 32'h1);
    // Each event but the bus error, then transmit complete again to drop the early flag.
    for (int i = 0; i < 9; i++)
    begin
      pulse(i);
      rd_chk(8'h28);
    end
    pulse(0);
    rd_chk(8'h28);
    check({30'h0, tsh, rsh}, 32'h3);
    @(posedge clock);
    rel <= 4'b0101;
    @(posedge clock);
    rel <= 4'h0;
    @(posedge clock);
    #1 check({30'h0, tsh, rsh}, 32'h0);
    // Bus error categories with the interrupt path fully enabled.
    @(posedge clock);
    en <= 3'b110;
    for (int c = 0; c < 3; c++)
    begin
      @(posedge clock);
      berr <= c[2:0];
      pulse(9);
      rd_chk(8'h28);
      check({31'h0, irq}, 32'h1);
    end
    wr(32'h0);
    rd_chk(8'h28);
    wr(32'hffffffff);
    fl[16:1] = 16'h0;
    rd_chk(8'h28);
    // A lone bus error needs its own enable as well as the abnormal one.
    @(posedge clock);
    en <= 3'b010;
    pulse(9);
    repeat (2) @(posedge clock);
    #1 check({31'h0, irq}, 32'h0);
    @(posedge clock);
    en <= 3'b110;
    repeat (2) @(posedge clock);
    #1 check({31'h0, irq}, 32'h1);
    // Timer expiry lands on the same edge as its own clear and wins.
    @(posedge clock);
    csr_wr <= 1'b1;
    csr_wdata <= 32'h00000800;
    ev[8] <= 1'b1;
    @(posedge clock);
    csr_wr <= 1'b0;
    ev[8] <= 1'b0;
    fl[11] = 1'b1;
    rd_chk(8'h28);
    @(posedge clock);
    en <= 3'b001;
    repeat (3) @(posedge clock);
    #1 check({31'h0, irq}, 32'h1);
    @(posedge clock);
    soft_rst <= 1'b1;
    @(posedge clock);
    soft_rst <= 1'b0;
    fl = '0;
    berr = 3'h0;
    rd_chk(8'h28);
    stop_test();
  end
endmodule
